/* include/pbdt_params.svh */
/*
 Constants of the pixel buffer with per-byte dirty tags.
 Assumes inclusion by bare name from the include folder.
*/
`ifndef PBDT_PARAMS_SVH
`define PBDT_PARAMS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PBDT_BLOCKS 8
`define PBDT_WORDS_PER_BLOCK 8
`define PBDT_WORD_BITS 32
`define PBDT_BLOCK_BITS 256
`define PBDT_TAG_BITS 32
`define PBDT_ADDR_BITS 6
`define PBDT_BLK_LSB 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PBDT_PIPE_STAGES 7

// ----------------------------------------------------------------
// Pixel port opcodes, taken with the write enable high
// ----------------------------------------------------------------
`define PBDT_OPC_NORMAL_WR 3'h0
`define PBDT_OPC_INITIAL_WR 3'h1
`define PBDT_OPC_REPLACE_TAG 3'h2
`define PBDT_OPC_OR_TAG 3'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PBDT_TAG_RESET 32'h0000_0000
`define PBDT_DATA_RESET 32'h0000_0000

`endif

/* include/pbdt_pkg.sv */
/*
 Types shared by the pixel buffer and its tag update unit.
 Assumes the constants header is on the include path.
*/
`include "pbdt_params.svh"

package pbdt_pkg;

  typedef logic [2:0] pbdt_blk_t;
  typedef logic [2:0] pbdt_word_t;

  typedef enum logic [2:0] {
    PBDT_OP_NONE,
    PBDT_OP_READ,
    PBDT_OP_NORMAL_WR,
    PBDT_OP_INITIAL_WR,
    PBDT_OP_REPLACE_TAG,
    PBDT_OP_OR_TAG
  } pbdt_op_t;

endpackage

/* hdl/pbdt_tag_update.sv */
/*
 Combinational next value of one block's dirty tag for a pixel
 port operation at the last pipeline stage.
 Assumes the caller selects the addressed block's tag.
*/
`timescale 1ns/1ps
`include "pbdt_params.svh"

module pbdt_tag_update (
  input wire logic [31:0] old_tag,
  input wire pbdt_pkg::pbdt_op_t op,
  input wire pbdt_pkg::pbdt_word_t word,
  input wire logic [3:0] lane_en,
  input wire logic [31:0] bus_data,
  output logic [31:0] next_tag
);
  import pbdt_pkg::*;

  logic [31:0] word_bits;

  // ----------------------------------------------------------------
  // Byte b of word n sits on tag bit n + 8*b
  // ----------------------------------------------------------------
  always_comb begin
    word_bits = `PBDT_TAG_RESET;
    for (int b = 0; b < 4; b++) begin
      word_bits[b * 8 + int'(word)] = lane_en[b];
    end
  end

  // ----------------------------------------------------------------
  // Tag result per operation
  // ----------------------------------------------------------------
  always_comb begin
    unique case (op)
      PBDT_OP_NORMAL_WR: next_tag = old_tag | word_bits;
      PBDT_OP_INITIAL_WR: next_tag = word_bits;
      PBDT_OP_REPLACE_TAG: next_tag = bus_data;
      PBDT_OP_OR_TAG: next_tag = old_tag | bus_data;
      default: next_tag = old_tag;
    endcase
  end

endmodule

/* hdl/pbdt_pixel_buffer.sv */
/*
 Pixel buffer of eight 256-bit blocks with per-byte dirty tags,
 a 7-stage pixel port and a block transfer port to the DRAM banks.
 Assumes the rendering controller and DRAM logic share clk_sys.
*/
`timescale 1ns/1ps
`include "pbdt_params.svh"

// Operation
// - Eight 256-bit blocks, whole-block DRAM transfers
// - Address: upper three block, lower three word
// - Word bytes map to bus lanes 0..3
// - One dirty tag bit per byte
// - Block load from DRAM clears its tags
// - Store writes tagged bytes only, plane masked
// - Reads neither change tags nor see them
// - Normal write ORs lane enables into tags
// - Initial write loads enables, clears other tags
// - Writes store enabled bytes from the bus
// - Replace tag overwrites all block tags
// - OR tag merges bus into block tags
// - Enables ride pipeline, applied at last stage
// - Word n tags on bits n+8b
// - Tags reach a pin only through the store bit enables
// - DRAM and pixel port run concurrently
// - Store bit needs tag and plane mask
module pbdt_pixel_buffer #(
  parameter int PIPE_STAGES = `PBDT_PIPE_STAGES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] pixel_issue_enables,
  input wire logic pixel_write_enable,
  input wire logic [2:0] pixel_opcode,
  input wire logic [5:0] pixel_word_address,
  input wire logic [3:0] byte_lane_enables,
  input wire logic [31:0] pixel_data_bus_in,
  output logic [31:0] pixel_data_bus_out,
  output logic [3:0] pixel_data_bus_oe_n,
  input wire logic dram_load_valid,
  input wire pbdt_pkg::pbdt_blk_t dram_load_block,
  input wire logic [255:0] dram_load_data,
  input wire logic dram_store_req,
  input wire pbdt_pkg::pbdt_blk_t dram_store_block,
  input wire logic [31:0] plane_mask,
  output logic dram_store_valid,
  output logic [255:0] dram_store_data,
  output logic [255:0] dram_store_bit_enables
);
  import pbdt_pkg::*;

  initial begin
    if (PIPE_STAGES < 1) begin
      $error("pipeline needs at least one stage");
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [255:0] blk_data [`PBDT_BLOCKS];
  logic [31:0] blk_tag [`PBDT_BLOCKS];

  // ----------------------------------------------------------------
  // Issue decode
  // ----------------------------------------------------------------
  logic issue;
  pbdt_op_t issue_op;

  assign issue = &pixel_issue_enables;

  always_comb begin
    issue_op = PBDT_OP_NONE;
    if (issue && !pixel_write_enable) begin
      issue_op = PBDT_OP_READ;
    end else if (issue) begin
      unique case (pixel_opcode)
        `PBDT_OPC_NORMAL_WR: issue_op = PBDT_OP_NORMAL_WR;
        `PBDT_OPC_INITIAL_WR: issue_op = PBDT_OP_INITIAL_WR;
        `PBDT_OPC_REPLACE_TAG: issue_op = PBDT_OP_REPLACE_TAG;
        `PBDT_OPC_OR_TAG: issue_op = PBDT_OP_OR_TAG;
        default: issue_op = PBDT_OP_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operation pipeline
  // ----------------------------------------------------------------
  pbdt_op_t pl_op [PIPE_STAGES];
  logic [5:0] pl_addr [PIPE_STAGES];
  logic [3:0] pl_be [PIPE_STAGES];
  logic [31:0] pl_data [PIPE_STAGES];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int s = 0; s < PIPE_STAGES; s++) begin
        pl_op[s] <= PBDT_OP_NONE;
      end
    end else begin
      pl_op[0] <= issue_op;
      for (int s = 1; s < PIPE_STAGES; s++) begin
        pl_op[s] <= pl_op[s - 1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int s = 0; s < PIPE_STAGES; s++) begin
        pl_addr[s] <= 6'h00;
        pl_be[s] <= 4'h0;
        pl_data[s] <= `PBDT_DATA_RESET;
      end
    end else begin
      pl_addr[0] <= pixel_word_address;
      pl_be[0] <= byte_lane_enables;
      pl_data[0] <= pixel_data_bus_in;
      for (int s = 1; s < PIPE_STAGES; s++) begin
        pl_addr[s] <= pl_addr[s - 1];
        pl_be[s] <= pl_be[s - 1];
        pl_data[s] <= pl_data[s - 1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Last stage
  // ----------------------------------------------------------------
  pbdt_op_t fin_op;
  pbdt_blk_t fin_blk;
  pbdt_word_t fin_word;
  logic [3:0] fin_be;
  logic [31:0] fin_data;
  logic fin_data_wr;
  logic fin_tag_wr;
  logic [31:0] fin_old_tag;
  logic [31:0] next_fin_tag;

  assign fin_op = pl_op[PIPE_STAGES - 1];
  assign fin_blk = pl_addr[PIPE_STAGES - 1][5:3];
  assign fin_word = pl_addr[PIPE_STAGES - 1][2:0];
  assign fin_be = pl_be[PIPE_STAGES - 1];
  assign fin_data = pl_data[PIPE_STAGES - 1];
  assign fin_data_wr = (fin_op == PBDT_OP_NORMAL_WR) ||
                       (fin_op == PBDT_OP_INITIAL_WR);
  assign fin_tag_wr = fin_data_wr ||
                      (fin_op == PBDT_OP_REPLACE_TAG) ||
                      (fin_op == PBDT_OP_OR_TAG);

  // A load in the same cycle has already cleared the tag
  assign fin_old_tag = (dram_load_valid && dram_load_block == fin_blk) ?
                       `PBDT_TAG_RESET : blk_tag[fin_blk];

  pbdt_tag_update u_tag_update (
    .old_tag(fin_old_tag),
    .op(fin_op),
    .word(fin_word),
    .lane_en(fin_be),
    .bus_data(fin_data),
    .next_tag(next_fin_tag)
  );

  // ----------------------------------------------------------------
  // Dirty tag store
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int b = 0; b < `PBDT_BLOCKS; b++) begin
        blk_tag[b] <= `PBDT_TAG_RESET;
      end
    end else begin
      if (dram_load_valid) begin
        blk_tag[dram_load_block] <= `PBDT_TAG_RESET;
      end
      if (fin_tag_wr) begin
        blk_tag[fin_blk] <= next_fin_tag;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel data store
  // ----------------------------------------------------------------
  logic [255:0] fin_merged;

  always_comb begin
    fin_merged = blk_data[fin_blk];
    if (dram_load_valid && dram_load_block == fin_blk) begin
      fin_merged = dram_load_data;
    end
    for (int b = 0; b < 4; b++) begin
      if (fin_be[b]) begin
        fin_merged[int'(fin_word) * 32 + b * 8 +: 8] =
          fin_data[b * 8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dram_load_valid) begin
      blk_data[dram_load_block] <= dram_load_data;
    end
    if (fin_data_wr) begin
      blk_data[fin_blk] <= fin_merged;
    end
  end

  // ----------------------------------------------------------------
  // Pixel port read answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pixel_data_bus_out <= `PBDT_DATA_RESET;
    end else if (fin_op == PBDT_OP_READ) begin
      pixel_data_bus_out <=
        blk_data[fin_blk][int'(fin_word) * 32 +: 32];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pixel_data_bus_oe_n <= 4'hf;
    end else if (fin_op == PBDT_OP_READ) begin
      pixel_data_bus_oe_n <= ~fin_be;
    end else begin
      pixel_data_bus_oe_n <= 4'hf;
    end
  end

  // ----------------------------------------------------------------
  // Block store to DRAM, independent of the pixel port
  // ----------------------------------------------------------------
  logic [255:0] next_store_en;
  logic [31:0] store_tag;

  assign store_tag = blk_tag[dram_store_block];

  generate
    for (genvar w = 0; w < `PBDT_WORDS_PER_BLOCK; w++) begin : g_word
      for (genvar b = 0; b < 4; b++) begin : g_byte
        assign next_store_en[w * 32 + b * 8 +: 8] =
          {8{store_tag[b * 8 + w]}} &
          plane_mask[b * 8 +: 8];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dram_store_valid <= 1'b0;
    end else begin
      dram_store_valid <= dram_store_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dram_store_data <= {8{`PBDT_DATA_RESET}};
      dram_store_bit_enables <= {8{`PBDT_DATA_RESET}};
    end else if (dram_store_req) begin
      dram_store_data <= blk_data[dram_store_block];
      dram_store_bit_enables <= next_store_en;
    end
  end

endmodule

/* sim/pbdt_checker.sv */
/*
 Port assertions of the pixel buffer.
 Assumes a bind onto pbdt_pixel_buffer.
*/
`timescale 1ns/1ps
module pbdt_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] pixel_issue_enables,
  input wire logic pixel_write_enable,
  input wire logic [3:0] byte_lane_enables,
  input wire logic [31:0] pixel_data_bus_out,
  input wire logic [3:0] pixel_data_bus_oe_n,
  input wire logic dram_load_valid,
  input wire pbdt_pkg::pbdt_blk_t dram_load_block,
  input wire logic [255:0] dram_load_data,
  input wire logic dram_store_req,
  input wire pbdt_pkg::pbdt_blk_t dram_store_block,
  input wire logic [31:0] plane_mask,
  input wire logic dram_store_valid,
  input wire logic [255:0] dram_store_data,
  input wire logic [255:0] dram_store_bit_enables
);
  import pbdt_pkg::*;
  logic rd;
  assign rd = pixel_issue_enables == 2'h3 && !pixel_write_enable;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // --------
  // Assertions
  // --------
  sequence quiet_load;
    (pixel_issue_enables != 2'h3)[*8] ##0 dram_load_valid;
  endsequence
  sequence store_same;
    dram_store_req && !dram_load_valid &&
      dram_store_block == $past(dram_load_block);
  endsequence
  store_answer_a: assert property (dram_store_req |=> dram_store_valid)
    else $error("store not answered");
  store_cause_a: assert property (dram_store_valid |-> $past(dram_store_req))
    else $error("store valid without request");
  mask_gate_a: assert property (dram_store_valid |->
    (dram_store_bit_enables & ~{8{$past(plane_mask)}}) == 256'h0)
    else $error("enable outside plane mask");
  load_clear_a: assert property (quiet_load ##1 store_same |=>
    dram_store_bit_enables == 256'h0) else $error("tags not cleared");
  load_data_a: assert property (quiet_load ##1 store_same |=>
    dram_store_data == $past(dram_load_data, 2)) else $error("load lost");
  read_lanes_a: assert property (rd |-> ##8
    pixel_data_bus_oe_n == ~$past(byte_lane_enables, 8))
    else $error("read lanes wrong");
  read_quiet_a: assert property (!$past(rd, 8) |->
    pixel_data_bus_oe_n == 4'hf) else $error("bus driven without read");
  out_hold_a: assert property (!$past(rd, 8) |->
    $stable(pixel_data_bus_out)) else $error("read data moved");
  store_hold_a: assert property (!dram_store_valid |->
    $stable(dram_store_data)) else $error("store data moved");
endmodule

/* sim/pbdt_ctl_model.sv */
/*
 Rendering controller model for the pixel and DRAM ports.
 Assumes its outputs feed the pixel buffer inputs on clk_sys.
*/
`timescale 1ns/1ps
module pbdt_ctl_model (
  input wire logic clk_sys,
  output logic [1:0] pixel_issue_enables,
  output logic pixel_write_enable,
  output logic [2:0] pixel_opcode,
  output logic [5:0] pixel_word_address,
  output logic [3:0] byte_lane_enables,
  output logic [31:0] ctl_data,
  output logic dram_load_valid,
  output pbdt_pkg::pbdt_blk_t dram_load_block,
  output logic [255:0] dram_load_data,
  output logic dram_store_req,
  output pbdt_pkg::pbdt_blk_t dram_store_block,
  output logic [31:0] plane_mask
);
  import pbdt_pkg::*;
  // --------
  // Drivers
  // --------
  initial begin
    {pixel_issue_enables, pixel_write_enable, pixel_opcode} = '0;
    {pixel_word_address, byte_lane_enables, ctl_data} = '0;
    {dram_load_valid, dram_load_block, dram_load_data} = '0;
    {dram_store_req, dram_store_block, plane_mask} = '0;
  end
  task automatic op(input logic [1:0] en, input logic we,
    input logic [2:0] opc, input logic [5:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge clk_sys);
    pixel_issue_enables <= en;
    pixel_write_enable <= we;
    pixel_opcode <= opc;
    pixel_word_address <= a;
    byte_lane_enables <= be;
    ctl_data <= d;
  endtask
  task automatic idle;
    @(posedge clk_sys);
    pixel_issue_enables <= 2'h0;
    ctl_data <= ~ctl_data;
  endtask
  task automatic load(input pbdt_blk_t b, input logic [255:0] d);
    @(posedge clk_sys);
    dram_load_valid <= 1'b1;
    dram_load_block <= b;
    dram_load_data <= d;
  endtask
  task automatic store(input pbdt_blk_t b, input logic [31:0] m);
    @(posedge clk_sys);
    dram_load_valid <= 1'b0;
    dram_load_data <= ~dram_load_data;
    dram_store_req <= 1'b1;
    dram_store_block <= b;
    plane_mask <= m;
    @(posedge clk_sys);
    dram_store_req <= 1'b0;
  endtask
endmodule

/* sim/pbdt_pixel_buffer_tb.sv */
/*
 Self-checking bench of the pixel buffer.
 Assumes the controller model and checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_mismatch++; $display("wrong value %0t %h %h", $time, a, b); end end
module pbdt_pixel_buffer_tb;
  import pbdt_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] pixel_issue_enables;
  logic pixel_write_enable, dram_load_valid, dram_store_req;
  logic [2:0] pixel_opcode;
  logic [5:0] pixel_word_address;
  logic [3:0] byte_lane_enables, pixel_data_bus_oe_n;
  logic [31:0] ctl_data, pixel_data_bus_in, pixel_data_bus_out, plane_mask;
  pbdt_blk_t dram_load_block, dram_store_block;
  logic [255:0] dram_load_data, dram_store_data, dram_store_bit_enables;
  logic dram_store_valid;
  logic [31:0] lane_m, exp_tag;
  logic [31:0] exp_w [8];
  int n_mismatch = 0;
  int comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  assign lane_m = {{8{pixel_data_bus_oe_n[3]}}, {8{pixel_data_bus_oe_n[2]}},
    {8{pixel_data_bus_oe_n[1]}}, {8{pixel_data_bus_oe_n[0]}}};
  assign pixel_data_bus_in = (pixel_data_bus_out & ~lane_m) |
    (ctl_data & lane_m);
  pbdt_ctl_model pm_u (.clk_sys, .pixel_issue_enables, .pixel_write_enable,
    .pixel_opcode, .pixel_word_address, .byte_lane_enables, .ctl_data,
    .dram_load_valid, .dram_load_block, .dram_load_data, .dram_store_req,
    .dram_store_block, .plane_mask);
  pbdt_pixel_buffer dut_u (.clk_sys, .reset_n, .pixel_issue_enables,
    .pixel_write_enable, .pixel_opcode, .pixel_word_address,
    .byte_lane_enables, .pixel_data_bus_in, .pixel_data_bus_out,
    .pixel_data_bus_oe_n, .dram_load_valid, .dram_load_block,
    .dram_load_data, .dram_store_req, .dram_store_block, .plane_mask,
    .dram_store_valid, .dram_store_data, .dram_store_bit_enables);
  // --------
  // Scenarios
  // --------
  function automatic logic [255:0] en_of(logic [31:0] t, logic [31:0] m);
    logic [255:0] e;
    for (int i = 0; i < 256; i++)
      e[i] = t[(i % 32) / 8 * 8 + i / 32] & m[i % 32];
    return e;
  endfunction
  function automatic logic [255:0] blk_of();
    logic [255:0] d;
    for (int w = 0; w < 8; w++)
      d[32 * w +: 32] = exp_w[w];
    return d;
  endfunction
  task automatic pix(logic we, logic [2:0] opc, logic [5:0] a,
    logic [3:0] be, logic [31:0] d);
    pm_u.op(2'h3, we, opc, a, be, d);
  endtask
  task automatic settle;
    pm_u.idle();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic check_store(logic [31:0] m);
    pm_u.store(3'h1, m);
    #1;
    `CHK(dram_store_valid, 1'b1)
    `CHK(dram_store_data, blk_of())
    `CHK(dram_store_bit_enables, en_of(exp_tag, m))
  endtask
  task automatic t_load;
    for (int w = 0; w < 8; w++)
      exp_w[w] = 32'h0101_0101 * (w + 1);
    exp_tag = 32'h0;
    pm_u.load(3'h1, blk_of());
    check_store(32'hffff_ffff);
  endtask
  task automatic t_replace;
    pix(1'b1, 3'h2, 6'h08, 4'hf, 32'ha5c3_0f21);
    settle();
    exp_tag = 32'ha5c3_0f21;
    check_store(32'hffff_00ff);
  endtask
  task automatic t_or;
    pix(1'b1, 3'h3, 6'h0f, 4'hf, 32'h1002_0004);
    pix(1'b1, 3'h7, 6'h08, 4'hf, 32'hffff_ffff);
    pm_u.op(2'h1, 1'b1, 3'h2, 6'h08, 4'hf, 32'h0);
    settle();
    exp_tag |= 32'h1002_0004;
    check_store(32'hffff_ffff);
  endtask
  task automatic t_normal;
    pix(1'b1, 3'h0, 6'h0d, 4'ha, 32'hdead_beef);
    pix(1'b0, 3'h0, 6'h0d, 4'h3, 32'h0);
    pm_u.idle();
    repeat (7) @(posedge clk_sys);
    #1;
    exp_w[5] = {8'hde, exp_w[5][23:16], 8'hbe, exp_w[5][7:0]};
    `CHK(pixel_data_bus_out, exp_w[5])
    `CHK(pixel_data_bus_oe_n, 4'hc)
    exp_tag |= 32'h2000_2000;
    check_store(32'hffff_ffff);
  endtask
  task automatic t_initial;
    pix(1'b1, 3'h1, 6'h0a, 4'h1, 32'h1234_5677);
    settle();
    exp_w[2][7:0] = 8'h77;
    exp_tag = 32'h0000_0004;
    check_store(32'hffff_ffff);
  endtask
  task automatic t_clash;
    pix(1'b1, 3'h0, 6'h08, 4'h8, 32'hcc00_0000);
    pm_u.idle();
    repeat (5) @(posedge clk_sys);
    for (int w = 0; w < 8; w++)
      exp_w[w] = ~exp_w[w];
    pm_u.load(3'h1, blk_of());
    exp_w[0][31:24] = 8'hcc;
    exp_tag = 32'h0100_0000;
    check_store(32'hffff_ffff);
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    t_load();
    t_replace();
    t_or();
    t_normal();
    t_initial();
    t_clash();
    conclude();
  end
endmodule
bind pbdt_pixel_buffer pbdt_checker chk_u (.clk_sys, .reset_n,
  .pixel_issue_enables, .pixel_write_enable, .byte_lane_enables,
  .pixel_data_bus_out, .pixel_data_bus_oe_n, .dram_load_valid,
  .dram_load_block, .dram_load_data, .dram_store_req, .dram_store_block,
  .plane_mask, .dram_store_valid, .dram_store_data, .dram_store_bit_enables);
